// ### logic/csr_pkg.sv
// shared constants and types of the dual-port control/status register bank
// assumes one 100 MHz clock domain; reset pins arrive asynchronously
package csr_pkg;

    // ********************************************************
    // space geometry
    // ********************************************************
    localparam int SPACE_BYTES = 4096;           // whole register space
    localparam int WORD_BYTES  = 4;              // one word per register
    localparam int ADDR_W      = $clog2(SPACE_BYTES / WORD_BYTES);
    localparam int NUM_REGS    = 8;              // implemented words
    localparam int IDX_W       = 3;              // index of implemented word
    localparam int STATUS_IDX  = 7;              // word with live status
    localparam int STAT_BUSY   = 0;              // preload running
    localparam int STAT_DONE   = 1;              // preload finished

    // ********************************************************
    // reset pin vector positions
    // ********************************************************
    localparam int PIN_HEALTHY = 0;              // board_healthy_n
    localparam int PIN_LOCAL   = 1;              // local_reset_in_n
    localparam int PIN_PCI     = 2;              // pci reset pin, low active
    localparam int NUM_PINS    = 3;

    typedef logic [31:0]                   word_t;
    typedef logic [NUM_REGS-1:0][31:0]     bank_t;

    // ********************************************************
    // per-bit access classes, word 7 listed first
    // ********************************************************
    localparam bank_t RO_MASK = {32'h0000_0003, 32'h0000_0000,
        32'h0000_0000, 32'h0000_000f, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'hffff_0000};
    localparam bank_t SH_MASK = {32'h0000_0000, 32'h0000_0000,
        32'h7fff_ffff, 32'h0000_00f0, 32'h0000_0000, 32'h0000_0000,
        32'hffff_ffff, 32'h0000_00ff};
    localparam bank_t LO_MASK = {32'h0000_0000, 32'hffff_ffff,
        32'h0000_0000, 32'h0000_0f00, 32'h0000_0000, 32'h00ff_ffff,
        32'h0000_0000, 32'h0000_0000};
    localparam bank_t PC_MASK = {32'h0000_ff00, 32'h0000_0000,
        32'h0000_0000, 32'h0000_f000, 32'h0000_ffff, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000};
    localparam bank_t PRE_MASK = {32'h0000_0000, 32'hffff_ffff,
        32'h0000_0000, 32'h0000_0ff0, 32'h0000_0000, 32'h00ff_0000,
        32'h0000_ffff, 32'h0000_00f0};
    // reset values; upper half of word 0 is an arbitrary code
    localparam bank_t REG_RESET = {32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0005, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h5a5a_0000};

    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        logic              valid;                // access request
        logic              write;                // 1 write, 0 read
        logic [ADDR_W-1:0] addr;                 // word index in space
        word_t             wdata;                // write data
    } port_req_s;

    typedef struct packed {
        logic  ack;                              // one-cycle completion
        word_t rdata;                            // read data
    } port_rsp_s;

    typedef struct packed {
        logic             req;                   // preload word wanted
        logic [IDX_W-1:0] index;                 // which word
    } ee_req_s;

    typedef struct packed {
        logic  valid;                            // word delivered
        word_t data;                             // preload word
    } ee_rsp_s;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_REQ  = 2'b01,
        LD_DONE = 2'b11
    } load_state_e;

    // ********************************************************
    // decoders
    // ********************************************************
    // address lands on an implemented word
    function automatic logic hit(input logic [ADDR_W-1:0] addr);
        hit = (addr < ADDR_W'(NUM_REGS));
    endfunction : hit

    // bits a port may write in a word
    function automatic word_t wr_mask(input logic [IDX_W-1:0] idx,
                                      input logic from_pci);
        wr_mask = SH_MASK[idx] | (from_pci ? PC_MASK[idx] : LO_MASK[idx]);
    endfunction : wr_mask

    // bits that are not reserved for an address
    function automatic word_t live_mask(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[IDX_W-1:0];
        live_mask = hit(addr) ? (RO_MASK[idx] | SH_MASK[idx] |
                                 LO_MASK[idx] | PC_MASK[idx]) : 32'h0;
    endfunction : live_mask

endpackage : csr_pkg

// ### logic/reset_combiner.sv
// synchronises the three reset pins and forms general and pci-side resets
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module reset_combiner (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // raw pins
    input  wire logic [csr_pkg::NUM_PINS-1:0]  pins,
    // combined resets, active high
    output logic                               general_reset,
    output logic                               pci_side_reset
);
    import csr_pkg::*;

    typedef struct packed {
        logic [NUM_PINS-1:0] sync1;              // first stage only
        logic [NUM_PINS-1:0] sync2;              // safe copy
        logic                gen;                // general reset
        logic                pci;                // pci-side reset
    } comb_state_s;

    // pins idle in their asserting levels
    localparam comb_state_s COMB_RESET = '{sync1: 3'h1, sync2: 3'h1,
                                           gen: 1'b1, pci: 1'b1};

    comb_state_s st_reg;                         // current state
    comb_state_s st_next;                        // next state

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.gen   = !st_reg.sync2[PIN_PCI] || !st_reg.sync2[PIN_LOCAL]
                        || st_reg.sync2[PIN_HEALTHY];
        st_next.pci   = !st_reg.sync2[PIN_PCI]
                        || st_reg.sync2[PIN_HEALTHY];
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= COMB_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign general_reset  = st_reg.gen;
    assign pci_side_reset = st_reg.pci;

    // ********************************************************
    // checks
    // ********************************************************
    logic gen_cause;                             // raw general condition
    logic pci_cause;                             // raw pci condition
    assign gen_cause = !pins[PIN_PCI] || !pins[PIN_LOCAL] || pins[PIN_HEALTHY];
    assign pci_cause = !pins[PIN_PCI] || pins[PIN_HEALTHY];

    AST_GEN_RESET: assert property (@(posedge clk) disable iff (reset)
        $past(!reset, 3) |-> general_reset == $past(gen_cause, 3))
        else $error("general reset does not follow pins");
    AST_PCI_RESET: assert property (@(posedge clk) disable iff (reset)
        $past(!reset, 3) |-> pci_side_reset == $past(pci_cause, 3))
        else $error("pci reset does not follow pins");

endmodule : reset_combiner
`default_nettype wire

// ### logic/csr_bank.sv
// dual-port control/status register bank with per-bit access classes
// assumes both ports are on clk; reset pins and preload source outside
//
// What this block does
// - 4 KB space, reachable from both ports
// - general reset: pci pin, local pin, unhealthy
// - pci reset: pci pin or unhealthy only
// - read-only fields ignore all writes
// - shared fields writable from both ports
// - local-only fields written only by local port
// - pci-only fields written only by pci port
// - preloadable fields loaded after pci reset ends
// - reserved bits always read as zero
`timescale 1ns/1ps
`default_nettype none
module csr_bank (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // reset pins
    input  wire logic               pci_rst_n,
    input  wire logic               local_reset_in_n,
    input  wire logic               board_healthy_n,
    // pci side access
    input  wire csr_pkg::port_req_s pci_req,
    output csr_pkg::port_rsp_s      pci_rsp,
    // local processor side access
    input  wire csr_pkg::port_req_s loc_req,
    output csr_pkg::port_rsp_s      loc_rsp,
    // serial preload source
    output csr_pkg::ee_req_s        ee_req,
    input  wire csr_pkg::ee_rsp_s   ee_rsp,
    // resets seen by the rest of the chip
    output logic                    general_reset,
    output logic                    pci_side_reset
);
    import csr_pkg::*;

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        bank_t            regs;                  // stored fields
        port_rsp_s        pci_rsp;               // pci answer
        port_rsp_s        loc_rsp;               // local answer
        load_state_e      ld_state;              // preload sequencer
        logic [IDX_W-1:0] ld_idx;                // word being loaded
        logic             pci_rst_seen;          // pci reset last cycle
    } bank_state_s;

    localparam bank_state_s BANK_RESET = '{regs: REG_RESET,
        pci_rsp: '0, loc_rsp: '0, ld_state: LD_IDLE, ld_idx: '0,
        pci_rst_seen: 1'b1};

    bank_state_s      st_reg;                    // current state
    bank_state_s      st_next;                   // next state
    logic [IDX_W-1:0] pci_idx;                   // pci word index
    logic [IDX_W-1:0] loc_idx;                   // local word index
    logic             pci_wr;                    // pci write to a word
    logic             loc_wr;                    // local write to a word
    word_t            status_word;               // live status bits

    // ********************************************************
    // reset conditioning
    // ********************************************************
    reset_combiner u_reset_combiner (
        .clk            (clk),
        .reset          (reset),
        .pins           ({pci_rst_n, local_reset_in_n, board_healthy_n}),
        .general_reset  (general_reset),
        .pci_side_reset (pci_side_reset)
    );

    // index decode, whole 4 KB space decoded
    assign pci_idx = pci_req.addr[IDX_W-1:0];
    assign loc_idx = loc_req.addr[IDX_W-1:0];
    assign pci_wr  = pci_req.valid && pci_req.write && hit(pci_req.addr);
    assign loc_wr  = loc_req.valid && loc_req.write && hit(loc_req.addr);

    // sequencer state shown in read-only status bits
    always_comb begin
        status_word            = '0;
        status_word[STAT_BUSY] = (st_reg.ld_state == LD_REQ);
        status_word[STAT_DONE] = (st_reg.ld_state == LD_DONE);
    end

    // read value: stored bits, live status, reserved forced low
    function automatic word_t read_word(input bank_t regs,
                                        input logic [ADDR_W-1:0] addr,
                                        input word_t stat);
        word_t v;
        v = regs[addr[IDX_W-1:0]];
        if (addr == ADDR_W'(STATUS_IDX)) begin
            v = (v & ~RO_MASK[STATUS_IDX]) | (stat & RO_MASK[STATUS_IDX]);
        end
        read_word = v & live_mask(addr);
    endfunction : read_word

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        st_next = st_reg;
        // every access completes next cycle, refused or not
        st_next.pci_rsp.ack   = pci_req.valid;
        st_next.loc_rsp.ack   = loc_req.valid;
        st_next.pci_rsp.rdata = (pci_req.valid && !pci_req.write) ?
            read_word(st_reg.regs, pci_req.addr, status_word) : '0;
        st_next.loc_rsp.rdata = (loc_req.valid && !loc_req.write) ?
            read_word(st_reg.regs, loc_req.addr, status_word) : '0;
        // general reset loads reset values into fields, else port writes
        if (general_reset) begin
            st_next.regs = REG_RESET;
        end else begin
            // local port: shared and local-only bits
            if (loc_wr) begin
                st_next.regs[loc_idx] =
                    (st_reg.regs[loc_idx] & ~wr_mask(loc_idx, 1'b0)) |
                    (loc_req.wdata & wr_mask(loc_idx, 1'b0));
            end
            // pci port: shared and pci-only bits, wins on overlap
            if (pci_wr) begin
                st_next.regs[pci_idx] =
                    (st_next.regs[pci_idx] & ~wr_mask(pci_idx, 1'b1)) |
                    (pci_req.wdata & wr_mask(pci_idx, 1'b1));
            end
        end
        // preload sequencer, restarted by each pci reset
        st_next.pci_rst_seen = pci_side_reset;
        if (pci_side_reset) begin
            st_next.ld_state = LD_IDLE;
            st_next.ld_idx   = '0;
        end else begin
            case (st_reg.ld_state)
                LD_IDLE: begin
                    // start on the cycle after pci reset ends
                    if (st_reg.pci_rst_seen) begin
                        st_next.ld_state = LD_REQ;
                    end
                end
                LD_REQ: begin
                    // only preloadable bits take the word
                    if (ee_rsp.valid) begin
                        st_next.regs[st_reg.ld_idx] =
                            (st_next.regs[st_reg.ld_idx] &
                             ~PRE_MASK[st_reg.ld_idx]) |
                            (ee_rsp.data & PRE_MASK[st_reg.ld_idx]);
                        if (st_reg.ld_idx == IDX_W'(NUM_REGS - 1)) begin
                            st_next.ld_state = LD_DONE;
                        end else begin
                            st_next.ld_idx = st_reg.ld_idx + 1'b1;
                        end
                    end
                end
                LD_DONE: begin
                    st_next.ld_state = LD_DONE;
                end
                default: begin
                    st_next.ld_state = LD_IDLE;
                end
            endcase
        end
        // read-only bits never change after any write
        st_next.regs = (st_next.regs & ~RO_MASK) | (REG_RESET & RO_MASK);
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= BANK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign pci_rsp      = st_reg.pci_rsp;
    assign loc_rsp      = st_reg.loc_rsp;
    // one driver for the whole preload request
    assign ee_req = '{req: (st_reg.ld_state == LD_REQ),
                      index: st_reg.ld_idx};

    // ********************************************************
    // checks
    // ********************************************************
    logic  quiet;                                // no reset, no preload
    bank_t ro_view;                              // read-only bits
    bank_t lo_view;                              // local-only bits
    assign quiet   = !general_reset && (st_reg.ld_state != LD_REQ);
    assign ro_view = st_reg.regs & RO_MASK;
    assign lo_view = st_reg.regs & LO_MASK;

    AST_BOTH_ACK: assert property (@(posedge clk) disable iff (reset)
        pci_req.valid && loc_req.valid |=> pci_rsp.ack && loc_rsp.ack)
        else $error("access from a port not answered next cycle");
    AST_RO_HOLD: assert property (@(posedge clk) disable iff (reset)
        ##1 ro_view == $past(ro_view))
        else $error("read-only field changed");
    AST_PCI_SHARED: assert property (@(posedge clk) disable iff (reset)
        pci_wr && !loc_wr && quiet |=>
        ((st_reg.regs[$past(pci_idx)] ^ $past(pci_req.wdata)) &
         SH_MASK[$past(pci_idx)]) == 32'h0)
        else $error("pci write to shared field lost");
    AST_LOC_WRITE: assert property (@(posedge clk) disable iff (reset)
        loc_wr && !pci_wr && quiet |=>
        ((st_reg.regs[$past(loc_idx)] ^ $past(loc_req.wdata)) &
         (LO_MASK[$past(loc_idx)] | SH_MASK[$past(loc_idx)])) == 32'h0)
        else $error("local write lost");
    AST_PCI_WRITE: assert property (@(posedge clk) disable iff (reset)
        pci_wr && !loc_wr && quiet |=>
        ((st_reg.regs[$past(pci_idx)] ^ $past(pci_req.wdata)) &
         PC_MASK[$past(pci_idx)]) == 32'h0)
        else $error("pci write to pci-only field lost");
    AST_PCI_NO_LOCAL: assert property (@(posedge clk) disable iff (reset)
        pci_wr && !loc_wr && quiet |=> lo_view == $past(lo_view))
        else $error("pci write changed local-only field");
    AST_PRELOAD_START: assert property (@(posedge clk) disable iff (reset)
        $fell(pci_side_reset) |=> ee_req.req && ee_req.index == 3'h0)
        else $error("preload did not start after pci reset");
    AST_PRELOAD_DATA: assert property (@(posedge clk) disable iff (reset)
        ee_req.req && ee_rsp.valid && !general_reset && !pci_side_reset |=>
        ((st_reg.regs[$past(ee_req.index)] ^ $past(ee_rsp.data)) &
         PRE_MASK[$past(ee_req.index)]) == 32'h0)
        else $error("preload word not stored");
    AST_RSV_ZERO: assert property (@(posedge clk) disable iff (reset)
        pci_req.valid && !pci_req.write |=>
        (pci_rsp.rdata & ~live_mask($past(pci_req.addr))) == 32'h0)
        else $error("reserved bit read as one");

    COV_PRELOAD_DONE: cover property (@(posedge clk) disable iff (reset)
        ee_req.req && ee_rsp.valid && ee_req.index == 3'h7);
    COV_BOTH_WRITE: cover property (@(posedge clk) disable iff (reset)
        pci_wr && loc_wr && pci_idx == loc_idx);
    COV_LOCAL_RESET: cover property (@(posedge clk) disable iff (reset)
        general_reset && !pci_side_reset);

endmodule : csr_bank
`default_nettype wire

// ### test/ee_source.sv
// behavioural serial preload source that answers the bank's word requests
// assumes the bench holds the word table steady and picks the answer delay
`timescale 1ns/1ps
`default_nettype none
module ee_source (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // preload handshake
    input  wire csr_pkg::ee_req_s ee_req,
    output csr_pkg::ee_rsp_s      ee_rsp,
    // word table and answer delay
    input  wire csr_pkg::bank_t   words,
    input  wire logic [1:0]       delay
);
    import csr_pkg::*;

    logic [1:0] wait_reg;                      // cycles left before answer

    // ********************************************************
    // one word per request, prompt or slow
    // ********************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ee_rsp   <= '0;
            wait_reg <= 2'h0;
        end else if (ee_rsp.valid) begin
            // word taken; old data must not linger
            ee_rsp.valid <= 1'b0;
            ee_rsp.data  <= ~ee_rsp.data;
            wait_reg     <= delay;
        end else if (ee_req.req && wait_reg == 2'h0) begin
            ee_rsp.valid <= 1'b1;
            ee_rsp.data  <= words[ee_req.index];
        end else begin
            // idle data keeps changing
            ee_rsp.data <= ~ee_rsp.data;
            if (wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
        end
    end
endmodule : ee_source
`default_nettype wire

// ### test/dual_port_csr_access_rules_test.sv
// self-checking bench for the dual-port register bank
// assumes a 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module dual_port_csr_access_rules_test;
    import csr_pkg::*;

    // ********************************************************
    // signals and bench state
    // ********************************************************
    logic      clk, reset, general_reset, pci_side_reset;
    logic      pci_rst_n, local_reset_in_n, board_healthy_n;
    port_req_s pci_req, loc_req;               // requests driven here
    port_rsp_s pci_rsp, loc_rsp;               // answers seen
    ee_req_s   ee_req;                         // preload request
    ee_rsp_s   ee_rsp;                         // preload answer
    bank_t     ee_words;                       // preload content
    logic [1:0] ee_delay;                      // preload answer delay
    int        n_errors, checked, cycles, seed;
    word_t     mirror [NUM_REGS];              // expected field values
    logic      pe_ack, le_ack;                 // ack expected next cycle
    word_t     pe_rd, le_rd;                   // read data expected

    csr_bank dut (.clk(clk), .reset(reset), .pci_rst_n(pci_rst_n),
        .local_reset_in_n(local_reset_in_n),
        .board_healthy_n(board_healthy_n), .pci_req(pci_req),
        .pci_rsp(pci_rsp), .loc_req(loc_req), .loc_rsp(loc_rsp),
        .ee_req(ee_req), .ee_rsp(ee_rsp), .general_reset(general_reset),
        .pci_side_reset(pci_side_reset));
    ee_source src (.clk(clk), .reset(reset), .ee_req(ee_req),
        .ee_rsp(ee_rsp), .words(ee_words), .delay(ee_delay));

    // clock and hang guard
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ********************************************************
    // model and helpers
    // ********************************************************
    // register value as a read should see it
    function automatic word_t rd_model(input logic [ADDR_W-1:0] a);
        return (a < 10'(NUM_REGS)) ? mirror[a[2:0]] : 32'h0;
    endfunction : rd_model

    // write through the mask of the writing port
    task automatic apply(input logic [ADDR_W-1:0] a, input word_t d,
                         input logic from_pci);
        word_t m;
        if (a < 10'(NUM_REGS)) begin
            m = SH_MASK[a[2:0]] |
                (from_pci ? PC_MASK[a[2:0]] : LO_MASK[a[2:0]]);
            mirror[a[2:0]] = (mirror[a[2:0]] & ~m) | (d & m);
        end
    endtask : apply

    // random access, never a one on a reserved bit
    function automatic port_req_s rnd_req();
        port_req_s r;
        r.valid = 1'($random(seed));
        r.write = 1'($random(seed));
        r.addr  = 10'($random(seed) & 15);
        if (r.addr == 10'h00f) r.addr = 10'h3ff;
        r.wdata = $random(seed);
        if (r.addr < 10'(NUM_REGS)) begin
            r.wdata &= RO_MASK[r.addr[2:0]] | SH_MASK[r.addr[2:0]] |
                       LO_MASK[r.addr[2:0]] | PC_MASK[r.addr[2:0]];
        end else begin
            r.wdata = 32'h0;
        end
        return r;
    endfunction : rnd_req

    task automatic check(input string what, input word_t exp,
                         input word_t got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one cycle: check last answers, drive both ports, update model
    task automatic step(input port_req_s p, input port_req_s l);
        @(negedge clk);
        check("pci_ack", 32'(pe_ack), 32'(pci_rsp.ack));
        if (pe_ack) check("pci_rdata", pe_rd, pci_rsp.rdata);
        check("loc_ack", 32'(le_ack), 32'(loc_rsp.ack));
        if (le_ack) check("loc_rdata", le_rd, loc_rsp.rdata);
        pci_req  = p;
        loc_req  = l;
        ee_delay = 2'($random(seed));
        pe_ack   = p.valid;
        le_ack   = l.valid;
        pe_rd    = p.write ? 32'h0 : rd_model(p.addr);
        le_rd    = l.write ? 32'h0 : rd_model(l.addr);
        // local first, pci overlays in the same cycle
        if (l.valid && l.write) apply(l.addr, l.wdata, 1'b0);
        if (p.valid && p.write) apply(p.addr, p.wdata, 1'b1);
    endtask : step

    // read words 0..last from both ports at once
    task automatic sweep(input int last);
        port_req_s r;
        r = '0;
        r.valid = 1'b1;
        for (int a = 0; a <= last; a++) begin
            r.addr = 10'(a);
            step(r, r);
        end
        step('0, '0);
    endtask : sweep

    // wait for a whole preload pass, then expect its words
    task automatic wait_preload();
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 300; k++) begin
            step('0, '0);
            if (ee_req.req === 1'b1) seen = 1'b1;
            else if (seen) break;
        end
        check("preload_done", 32'h1, 32'(seen && ee_req.req === 1'b0));
        for (int i = 0; i < NUM_REGS; i++) begin
            mirror[i] = (REG_RESET[i] & ~PRE_MASK[i]) |
                        (ee_words[i] & PRE_MASK[i]);
        end
        mirror[STATUS_IDX][STAT_DONE] = 1'b1;
    endtask : wait_preload

    task automatic end_of_test();
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        seed = 26;
        n_errors = 0;
        checked = 0;
        cycles = 0;
        reset = 1'b1;
        {pci_rst_n, local_reset_in_n, board_healthy_n} = 3'b110;
        pci_req = '0;
        loc_req = '0;
        ee_delay = 2'h0;
        {pe_ack, le_ack, pe_rd, le_rd} = '0;
        for (int i = 0; i < NUM_REGS; i++) ee_words[i] = $random(seed);
        repeat (8) @(negedge clk);
        reset = 1'b0;
        wait_preload();
        sweep(15);
        repeat (400) step(rnd_req(), rnd_req());
        step('0, '0);
        // local reset alone: fields to reset values, no new preload
        local_reset_in_n = 1'b0;
        repeat (6) step('0, '0);
        check("gen_local", 32'h1, 32'(general_reset));
        check("pci_local", 32'h0, 32'(pci_side_reset));
        local_reset_in_n = 1'b1;
        for (int i = 0; i < NUM_REGS; i++) mirror[i] = REG_RESET[i];
        mirror[STATUS_IDX][STAT_DONE] = 1'b1;   // preload stays done
        repeat (6) step('0, '0);
        sweep(15);
        // every pin combination
        for (int c = 0; c < 8; c++) begin
            {pci_rst_n, local_reset_in_n, board_healthy_n} = 3'(c);
            repeat (5) step('0, '0);
            check("gen_reset", 32'(!c[2] | !c[1] | c[0]), 32'(general_reset));
            check("pci_reset", 32'(!c[2] | c[0]), 32'(pci_side_reset));
        end
        {pci_rst_n, local_reset_in_n, board_healthy_n} = 3'b110;
        wait_preload();
        repeat (300) step(rnd_req(), rnd_req());
        sweep(15);
        end_of_test();
    end
endmodule : dual_port_csr_access_rules_test
`default_nettype wire
